// ==== cte_host_model.sv ====
// Serial host that shifts command bytes into the block
`timescale 1ns/100ps
module cte_host_model (
	// Serial pins, driven high when idle
	output logic scl,
	output logic sda
);
	realtime latch_t;
	initial begin
		scl = 1'b1;
		sda = 1'b1;
		latch_t = 0;
	end
	// 800 ns per bit; the clock stands high between frames
	task automatic send(input logic [7:0] cmd);
		for (int i = 7; i >= 0; i--) begin
			sda = cmd[i];
			#400 scl = 1'b0;
			if (i == 0) latch_t = $realtime;
			#400 scl = 1'b1;
		end
		sda = 1'b1;
	endtask
endmodule

// ==== cte_map.svh ====
// Constants for the conversion timing and excitation control block
// Functional notes
// [RQ1] First conversion after any start is fully settled; no discarded cycles.
// [RQ2] Conversion periods are counts of conversion clock periods, not absolute time.
// [RQ3] Continuous period runs from one conversion_done_n falling edge to the next.
// [RQ4] First continuous conversion starts 28.5 or 105 periods after start latch.
// [RQ5] Commands latch on eighth SCL falling edge; timing counts start there.
// [RQ6] Continuous periods 51192 down to 1036, same in normal and turbo.
// [RQ7] Single-shot time runs from command latch to done falling edge, rounded up.
// [RQ8] Normal single-shot takes 51213 down to 1061 periods per rate.
// [RQ9] Turbo single-shot takes 51217 down to 1065 periods per rate.
// [RQ10] Conversion clock is 1.024 MHz normal, 2.048 MHz turbo.
// [RQ11] Three-bit magnitude picks 10 to 1500 uA for both sources; zero is off.
// [RQ12] Each source has a three-bit route; both may share one pin.
// [RQ13] Sources need up to 200 us after magnitude write before current is valid.
// [RQ14] Host programs magnitude first, then routing.
// [RQ15] Single-shot keeps sources powered between conversions if magnitude nonzero.
// [RQ16] Sleep command switches both sources off regardless of magnitude.
// [RQ17] Bias on when magnitude nonzero; output current only with nonzero route.
// [RQ18] Start during continuous mode aborts and restarts from the startup delay.
`ifndef CTE_MAP_SVH
`define CTE_MAP_SVH
`define CTE_CLK_HZ 10000000
`define CTE_FCLK_NORMAL_HZ 1024000
`define CTE_FCLK_TURBO_HZ 2048000
// Startup delays in half periods: 28.5 and 105 periods
`define CTE_START_HALF_NORMAL 16'd57
`define CTE_START_HALF_TURBO 16'd210
`define CTE_EXC_START_US 200
`define CTE_EXC_START_CYC ((`CTE_EXC_START_US * (`CTE_CLK_HZ / 1000000)))
// Register offsets
`define CTE_OFS_CTRL 8'h00
`define CTE_OFS_EXC 8'h04
`define CTE_OFS_STATUS 8'h08
`define CTE_OFS_IRQ_STAT 8'h0c
`define CTE_OFS_IRQ_MASK 8'h10
// Control fields
`define CTE_CTRL_RATE_LSB 0
`define CTE_CTRL_TURBO 3
`define CTE_CTRL_SINGLE 4
// Excitation fields
`define CTE_EXC_MAG_LSB 0
`define CTE_EXC_R1_LSB 4
`define CTE_EXC_R2_LSB 8
// Interrupt bits
`define CTE_IRQ_DONE 0
`define CTE_IRQ_EXC_READY 1
// Command codes, latched on the eighth SCL fall
`define CTE_CMD_START 8'h08
`define CTE_CMD_SLEEP 8'h02
`endif

// ==== cte_pkg.sv ====
// Types for the conversion timing and excitation control block
package cte_pkg;
	typedef enum logic [1:0] {
		CTE_IDLE = 2'b00,
		CTE_STARTUP = 2'b01,
		CTE_CONVERT = 2'b11
	} cte_state_e;
	typedef struct packed {
		logic [2:0] magnitude;
		logic [2:0] first_route;
		logic [2:0] second_route;
	} cte_exc_s;
	typedef struct packed {
		cte_state_e state;
		logic [2:0] rate;
		logic turbo;
		logic single;
		cte_exc_s exc;
		logic sleeping;
		logic [1:0] irq_stat;
		logic [1:0] irq_mask;
		logic [15:0] half_cnt;
		logic [23:0] phase_acc;
		logic cnv_tick;
		logic [15:0] cnv_cnt;
		logic [15:0] cnv_target;
		logic [11:0] exc_cnt;
		logic exc_ready;
		logic done_n;
		logic bias_en;
		logic src1_en;
		logic src2_en;
		logic [2:0] scl_sync;
		logic [2:0] sda_sync;
		logic [7:0] shift;
		logic [3:0] bit_cnt;
		logic wb_ack;
		logic [31:0] wb_dat;
		logic irq;
	} cte_state_s;
endpackage

// ==== cte_top.sv ====
// Conversion timing sequencer and excitation source control
`timescale 1ns/100ps
`include "cte_map.svh"
module cte_top import cte_pkg::*; #(
	parameter int EXC_START_CYCLES = `CTE_EXC_START_CYC
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Serial command link
	input wire logic SCL,
	input wire logic SDA,
	// Converter outputs
	output logic CONVERSION_DONE_N,
	output logic EXC_BIAS_EN,
	output logic EXC_SRC1_EN,
	output logic EXC_SRC2_EN,
	output logic [2:0] EXC_MAGNITUDE,
	output logic [2:0] FIRST_SOURCE_ROUTE,
	output logic [2:0] SECOND_SOURCE_ROUTE,
	output logic IRQ
);
	cte_state_s s_ff, nxt_s;

	function automatic logic [15:0] cont_len(input logic [2:0] r);
		case (r)
			3'h0: cont_len = 16'd51192;
			3'h1: cont_len = 16'd22780;
			3'h2: cont_len = 16'd11532;
			3'h3: cont_len = 16'd5916;
			3'h4: cont_len = 16'd3116;
			3'h5: cont_len = 16'd1724;
			default: cont_len = 16'd1036;
		endcase
	endfunction

	// Single-shot extra over continuous: normal 21/25, turbo 25/29
	function automatic logic [15:0] single_len(input logic [2:0] r, input logic t);
		logic [15:0] extra;
		extra = (r == 3'h0) ? (t ? 16'd25 : 16'd21) : (t ? 16'd29 : 16'd25);
		single_len = cont_len(r) + extra;
	endfunction

	logic wb_req;
	logic wb_wr;
	logic scl_fall;
	logic cmd_start;
	logic cmd_sleep;
	logic [23:0] inc;
	logic [24:0] acc_sum;
	logic half_tick;
	logic [31:0] rd;
	assign wb_req = WB_CYC_I && WB_STB_I && !s_ff.wb_ack;
	assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
	assign scl_fall = s_ff.scl_sync[2] && !s_ff.scl_sync[1];

	always_comb begin
		nxt_s = s_ff;
		cmd_start = 1'b0;
		cmd_sleep = 1'b0;
		nxt_s.scl_sync = {s_ff.scl_sync[1:0], SCL};
		nxt_s.sda_sync = {s_ff.sda_sync[1:0], SDA};
		nxt_s.cnv_tick = 1'b0;
		// Phase accumulator makes half-period ticks of the conversion clock
		inc = s_ff.turbo ? 24'd6872948 : 24'd3436474; // RQ10
		acc_sum = {1'b0, s_ff.phase_acc} + {1'b0, inc};
		half_tick = acc_sum[24];
		nxt_s.phase_acc = acc_sum[23:0];
		// Command byte shift; latch on the eighth SCL fall
		if (scl_fall) begin
			nxt_s.shift = {s_ff.shift[6:0], s_ff.sda_sync[2]};
			if (s_ff.bit_cnt == 4'd7) begin
				nxt_s.bit_cnt = 4'd0;
				cmd_start = ({s_ff.shift[6:0], s_ff.sda_sync[2]} == `CTE_CMD_START); // RQ5
				cmd_sleep = ({s_ff.shift[6:0], s_ff.sda_sync[2]} == `CTE_CMD_SLEEP);
			end else begin
				nxt_s.bit_cnt = s_ff.bit_cnt + 4'd1;
			end
		end
		// Register writes
		if (wb_wr) begin
			unique case (WB_ADR_I)
				`CTE_OFS_CTRL: begin
					nxt_s.rate = WB_DAT_I[`CTE_CTRL_RATE_LSB +: 3];
					nxt_s.turbo = WB_DAT_I[`CTE_CTRL_TURBO];
					nxt_s.single = WB_DAT_I[`CTE_CTRL_SINGLE];
				end
				`CTE_OFS_EXC: begin
					if (WB_DAT_I[`CTE_EXC_MAG_LSB +: 3] != s_ff.exc.magnitude) begin
						nxt_s.exc_cnt = 12'(EXC_START_CYCLES); // RQ13
						nxt_s.exc_ready = 1'b0;
					end
					nxt_s.exc.magnitude = WB_DAT_I[`CTE_EXC_MAG_LSB +: 3]; // RQ11
					nxt_s.exc.first_route = WB_DAT_I[`CTE_EXC_R1_LSB +: 3]; // RQ12
					nxt_s.exc.second_route = WB_DAT_I[`CTE_EXC_R2_LSB +: 3];
					nxt_s.sleeping = 1'b0;
				end
				`CTE_OFS_IRQ_STAT: nxt_s.irq_stat = s_ff.irq_stat & ~WB_DAT_I[1:0];
				`CTE_OFS_IRQ_MASK: nxt_s.irq_mask = WB_DAT_I[1:0];
				default: ;
			endcase
		end
		// Excitation startup wait
		if (s_ff.exc_cnt != 12'd0 && !(wb_wr && WB_ADR_I == `CTE_OFS_EXC)) begin
			nxt_s.exc_cnt = s_ff.exc_cnt - 12'd1;
			if (s_ff.exc_cnt == 12'd1) begin
				nxt_s.exc_ready = 1'b1;
				nxt_s.irq_stat[`CTE_IRQ_EXC_READY] = 1'b1;
			end
		end
		// Conversion sequencer
		nxt_s.done_n = 1'b1;
		unique case (s_ff.state)
			CTE_IDLE: ;
			CTE_STARTUP: begin
				if (half_tick) begin
					nxt_s.half_cnt = s_ff.half_cnt + 16'd1;
					if (s_ff.half_cnt + 16'd1 >= (s_ff.turbo ? `CTE_START_HALF_TURBO : `CTE_START_HALF_NORMAL)) begin // RQ4
						nxt_s.state = CTE_CONVERT;
						nxt_s.half_cnt = 16'd0;
						nxt_s.cnv_cnt = 16'd0;
						nxt_s.cnv_target = cont_len(s_ff.rate); // RQ6
					end
				end
			end
			CTE_CONVERT: begin
				// Counts whole periods: every second half tick
				if (half_tick) begin
					nxt_s.half_cnt = {15'd0, ~s_ff.half_cnt[0]};
					if (s_ff.half_cnt[0]) begin // RQ2
						nxt_s.cnv_cnt = s_ff.cnv_cnt + 16'd1;
						if (s_ff.cnv_cnt + 16'd1 >= s_ff.cnv_target) begin
							// Single-cycle settling: every period ends in a valid result
							nxt_s.done_n = 1'b0; // RQ1 RQ3
							nxt_s.irq_stat[`CTE_IRQ_DONE] = 1'b1;
							nxt_s.cnv_cnt = 16'd0;
							nxt_s.cnv_target = cont_len(s_ff.rate);
							if (s_ff.single) begin
								nxt_s.state = CTE_IDLE; // RQ15
							end
						end
					end
				end
			end
			default: nxt_s.state = CTE_IDLE;
		endcase
		// A start aborts whatever runs and restarts timing
		if (cmd_start) begin
			nxt_s.half_cnt = 16'd0;
			nxt_s.cnv_cnt = 16'd0;
			nxt_s.sleeping = 1'b0;
			if (s_ff.single) begin
				nxt_s.state = CTE_CONVERT; // RQ7
				nxt_s.cnv_target = single_len(s_ff.rate, s_ff.turbo); // RQ8 RQ9
			end else begin
				nxt_s.state = CTE_STARTUP; // RQ18
			end
		end
		if (cmd_sleep) begin
			nxt_s.state = CTE_IDLE;
			nxt_s.sleeping = 1'b1; // RQ16
		end
		// Excitation enables
		nxt_s.bias_en = (nxt_s.exc.magnitude != 3'h0) && !nxt_s.sleeping; // RQ15 RQ17
		nxt_s.src1_en = nxt_s.bias_en && nxt_s.exc_ready && (nxt_s.exc.first_route != 3'h0);
		nxt_s.src2_en = nxt_s.bias_en && nxt_s.exc_ready && (nxt_s.exc.second_route != 3'h0);
		// Bus answer one cycle after request
		rd = 32'h0;
		unique case (WB_ADR_I)
			`CTE_OFS_CTRL: rd = {27'h0, s_ff.single, s_ff.turbo, s_ff.rate};
			`CTE_OFS_EXC: rd = {21'h0, s_ff.exc.second_route, 1'b0, s_ff.exc.first_route, 1'b0,
				s_ff.exc.magnitude};
			`CTE_OFS_STATUS: rd = {26'h0, s_ff.exc_ready, s_ff.sleeping, s_ff.state, s_ff.done_n};
			`CTE_OFS_IRQ_STAT: rd = {30'h0, s_ff.irq_stat};
			`CTE_OFS_IRQ_MASK: rd = {30'h0, s_ff.irq_mask};
			default: rd = 32'h0;
		endcase
		nxt_s.wb_ack = wb_req;
		nxt_s.wb_dat = wb_req ? rd : 32'h0;
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
	end

	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			s_ff <= '0;
			s_ff.state <= CTE_IDLE;
			s_ff.done_n <= 1'b1;
			s_ff.exc_ready <= 1'b1;
			s_ff.scl_sync <= 3'h7;
			s_ff.sda_sync <= 3'h7;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign WB_DAT_O = s_ff.wb_dat;
	assign WB_ACK_O = s_ff.wb_ack;
	assign CONVERSION_DONE_N = s_ff.done_n;
	assign EXC_BIAS_EN = s_ff.bias_en;
	assign EXC_SRC1_EN = s_ff.src1_en;
	assign EXC_SRC2_EN = s_ff.src2_en;
	assign EXC_MAGNITUDE = s_ff.exc.magnitude;
	assign FIRST_SOURCE_ROUTE = s_ff.exc.first_route;
	assign SECOND_SOURCE_ROUTE = s_ff.exc.second_route;
	assign IRQ = s_ff.irq;
endmodule

// ==== cte_top_sva.sv ====
// Port checker for the conversion timing and excitation block
`timescale 1ns/100ps
module cte_top_sva #(
	parameter int EXC_START_CYCLES = 2000
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RSTN,
	// Register bus
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	// Converter outputs
	input wire logic CONVERSION_DONE_N,
	input wire logic EXC_BIAS_EN,
	input wire logic EXC_SRC1_EN,
	input wire logic EXC_SRC2_EN,
	input wire logic [2:0] EXC_MAGNITUDE,
	input wire logic [2:0] FIRST_SOURCE_ROUTE,
	input wire logic [2:0] SECOND_SOURCE_ROUTE
);
	// Fastest period is 5058 cycles; a few cycles go to oscillator jitter
	localparam int MIN_GAP = 5050;
	logic [15:0] gap_ff;
	logic [15:0] age_ff;
	always_ff @(posedge CLOCK or negedge RSTN) begin
		if (!RSTN) begin
			gap_ff <= '1;
			age_ff <= '1;
		end else begin
			gap_ff <= !CONVERSION_DONE_N ? 16'h0 : gap_ff + {15'h0, gap_ff != '1};
			age_ff <= $changed(EXC_MAGNITUDE) ? 16'h0 : age_ff + {15'h0, age_ff != '1};
		end
	end
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RSTN);
	a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("request left without ack");
	a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
	a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0) else $error("read data without ack");
	a_done_pulse: assert property ($fell(CONVERSION_DONE_N) |=> CONVERSION_DONE_N)
		else $error("done pulse too long");
	a_done_gap: assert property ($fell(CONVERSION_DONE_N) |-> gap_ff >= MIN_GAP)
		else $error("conversions too close");
	a_bias_level: assert property (EXC_BIAS_EN |-> EXC_MAGNITUDE != 3'h0)
		else $error("bias on with zero magnitude");
	a_src1_gate: assert property (EXC_SRC1_EN |-> EXC_BIAS_EN && FIRST_SOURCE_ROUTE != 3'h0)
		else $error("first source on without route");
	a_src2_gate: assert property (EXC_SRC2_EN |-> EXC_BIAS_EN && SECOND_SOURCE_ROUTE != 3'h0)
		else $error("second source on without route");
	a_src_wait: assert property (EXC_SRC1_EN || EXC_SRC2_EN |-> age_ff >= EXC_START_CYCLES - 2)
		else $error("source on before startup wait");
	c_done: cover property ($fell(CONVERSION_DONE_N));
	c_src: cover property ($rose(EXC_SRC1_EN));
	c_bias: cover property ($fell(EXC_BIAS_EN));
endmodule
bind cte_top cte_top_sva #(.EXC_START_CYCLES(EXC_START_CYCLES)) u_sva (.CLOCK(CLOCK), .RSTN(RSTN),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.CONVERSION_DONE_N(CONVERSION_DONE_N), .EXC_BIAS_EN(EXC_BIAS_EN), .EXC_SRC1_EN(EXC_SRC1_EN),
	.EXC_SRC2_EN(EXC_SRC2_EN), .EXC_MAGNITUDE(EXC_MAGNITUDE), .FIRST_SOURCE_ROUTE(FIRST_SOURCE_ROUTE),
	.SECOND_SOURCE_ROUTE(SECOND_SOURCE_ROUTE));

// ==== tb_cte_top.sv ====
// Self-checking bench for the conversion timing and excitation block
`timescale 1ns/100ps
`include "cte_map.svh"
module tb_cte_top;
	localparam int TOL = 6;
	logic clock, rstn, cyc, stb, we, ack, done_n, bias, src1, src2, irq, scl, sda;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] dat_i, dat_o, q;
	logic [2:0] mag, r1, r2;
	int miscompares = 0, total_checks = 0, seed = 32'h3bfe, m1, m2;
	realtime t_done, t0;
	bit got;
	// Lengths in conversion clock periods: continuous, single normal, single turbo
	int cont_t[7] = '{51192, 22780, 11532, 5916, 3116, 1724, 1036};
	int sgl_n[7] = '{51213, 22805, 11557, 5941, 3141, 1749, 1061};
	int sgl_t[7] = '{51217, 22809, 11561, 5945, 3145, 1753, 1065};
	cte_top #(.EXC_START_CYCLES(20)) DUT (.CLOCK(clock), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
		.WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .SCL(scl), .SDA(sda),
		.CONVERSION_DONE_N(done_n), .EXC_BIAS_EN(bias), .EXC_SRC1_EN(src1), .EXC_SRC2_EN(src2), .EXC_MAGNITUDE(mag),
		.FIRST_SOURCE_ROUTE(r1), .SECOND_SOURCE_ROUTE(r2), .IRQ(irq));
	cte_host_model host (.scl(scl), .sda(sda));
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// Half conversion periods to 100 ns cycles
	function automatic int cyc_of(int half, bit turbo);
		return half * 10000 / (turbo ? 4096 : 2048);
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Sync flops and the accumulator leave a few cycles of slack
	task automatic near(input int seen, input int exp);
		check((seen >= exp - TOL && seen <= exp + TOL) ? exp : seen, exp);
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		{cyc, stb, we, adr, dat_i} <= {2'b11, w, a, d};
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = dat_o;
		{cyc, stb} <= 2'b00;
		if (n >= 20) begin
			check(1, 0);
			end_sim();
		end
	endtask
	task automatic wait_done(input int lim, input bit must);
		int n;
		n = 0;
		got = 0;
		while (!got && n < lim) begin
			@(posedge clock);
			n++;
			got = (done_n === 1'b0);
		end
		t_done = $realtime;
		if (must && !got) begin
			check(0, 1);
			end_sim();
		end
	endtask
	task automatic start(input logic [7:0] ctrl, input int exp);
		wb(1, `CTE_OFS_CTRL, {24'h0, ctrl});
		host.send(`CTE_CMD_START);
		wait_done(20000, 1);
		near(int'((t_done - host.latch_t) / 100), exp);
	endtask
	initial begin
		{cyc, stb, we, adr, dat_i, q} = '0;
		sel = 4'h1;
		rstn = 1'b0;
		repeat (12) @(posedge clock);
		rstn <= 1'b1;
		wb(0, 8'h20, 0);
		check(q, 0);
		for (int m = 7; m >= 0; m--) begin
			wb(1, `CTE_OFS_EXC, m);
			@(posedge clock);
			check({mag, bias}, {3'(m), m != 0});
		end
		m1 = {$random(seed)} % 7 + 1;
		m2 = {$random(seed)} % 7 + 1;
		wb(1, `CTE_OFS_EXC, m1);
		wb(1, `CTE_OFS_EXC, m1 | (m2 << 4));
		check(src1, 0);
		repeat (30) @(posedge clock);
		check({src1, src2, r1, r2}, {2'b10, 3'(m2), 3'h0});
		wb(1, `CTE_OFS_EXC, m1 | (m2 << 8));
		@(posedge clock);
		check({src1, src2, r1, r2}, {2'b01, 3'h0, 3'(m2)});
		wb(1, `CTE_OFS_IRQ_MASK, 0);
		start(8'h06, cyc_of(`CTE_START_HALF_NORMAL + 2 * cont_t[6], 0));
		t0 = t_done;
		wait_done(20000, 1);
		near(int'((t_done - t0) / 100), cyc_of(2 * cont_t[6], 0));
		wb(0, `CTE_OFS_IRQ_STAT, 0);
		check({q[0], irq}, 2'b10);
		wb(1, `CTE_OFS_IRQ_MASK, 1);
		@(posedge clock);
		check(irq, 1);
		wb(1, `CTE_OFS_IRQ_STAT, 1);
		@(posedge clock);
		check(irq, 0);
		repeat (4000) @(posedge clock);
		start(8'h06, cyc_of(`CTE_START_HALF_NORMAL + 2 * cont_t[6], 0));
		host.send(`CTE_CMD_SLEEP);
		repeat (10) @(posedge clock);
		check({bias, src1}, 2'b00);
		wb(1, `CTE_OFS_EXC, m1 | (m2 << 4));
		start(8'h1e, cyc_of(2 * sgl_t[6], 1));
		wait_done(6000, 0);
		check({got, src1}, 2'b01);
		start(8'h16, cyc_of(2 * sgl_n[6], 0));
		start(8'h0e, cyc_of(`CTE_START_HALF_TURBO + 2 * cont_t[6], 1));
		end_sim();
	end
endmodule
